// ### dv/pmt8_far_side.sv
// pwm unit and serial port stand-in that count what the timer offers
module pmt8_far_side (
  input wire logic        ref_clk,    // clock
  input wire logic        rst,        // async reset
  input wire logic        matchPulse, // pwm time base
  input wire logic        shiftClk,   // serial shift clock
  output logic [15:0]     pulses,     // time base ticks seen
  output logic [15:0]     edges       // shift clock changes seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lastShift;
  // pulse counted per cycle high, so a stretched pulse overcounts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulses <= 16'h0000;
      edges <= 16'h0000;
      lastShift <= 1'h0;
    end else begin
      pulses <= pulses + {15'h0000, matchPulse};
      edges <= edges + {15'h0000, shiftClk ^ lastShift};
      lastShift <= shiftClk;
    end
  end
endmodule

// ### dv/pmt8_timer_properties.sv
// bus timing and match pulse checks of the 8-bit period timer
module pmt8_timer_props (
  input wire logic        ref_clk,    // clock
  input wire logic        rst,        // async reset
  input wire logic        hsel,       // slave select
  input wire logic [1:0]  htrans,     // transfer type
  input wire logic        hwrite,     // write when high
  input wire logic        hready,     // bus ready
  input wire logic        hreadyout,  // slave ready
  input wire logic        hresp,      // response
  input wire logic [31:0] hrdata,     // read data
  input wire logic        matchPulse, // unscaled match
  input wire logic        shiftClk    // shift clock source
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // address phase accepted by the slave
  wire logic take = hsel && htrans[1] && hready;

  resp_okay_a: assert property (hresp == 1'h0)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  idle_ready_a: assert property (!take |=> hreadyout)
    else $error("ready low without a read");
  match_once_a: assert property (matchPulse |=> !matchPulse [*3])
    else $error("match pulse too long or too close");
  shift_pair_a: assert property ($changed(shiftClk) |->
    matchPulse || $past(matchPulse))
    else $error("shift clock moved without a match");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside a read");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
endmodule

bind pmt8_timer pmt8_timer_props u_pmt8_timer_props (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .matchPulse(matchPulse),
  .shiftClk(shiftClk)
);

// ### dv/tb_period_match_timer_8bit.sv
// self-checking bench of the 8-bit period match timer
`include "pmt8_regs.svh"
module tb_period_match_timer_8bit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CTL = {`PMT8_IDX_CONTROL, 2'h0};
  localparam logic [15:0] LIM = {`PMT8_IDX_LIMIT, 2'h0};
  localparam logic [15:0] CNT = {`PMT8_IDX_COUNTER, 2'h0};
  localparam logic [15:0] FLG = {`PMT8_IDX_FLAGS, 2'h0};
  localparam logic [15:0] ENA = {`PMT8_IDX_ENABLES, 2'h0};
  logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp;
  logic        irq, matchPulse, shiftClk;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] haddr, pulses, edges;
  logic [31:0] hwdata, hrdata, rd, held;
  int          fails, n_compared, i, n, c;
  int          codes[3] = '{0, 3, 15};

  pmt8_timer u_pmt8_timer (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .matchPulse(matchPulse),
    .shiftClk(shiftClk));
  pmt8_far_side u_pmt8_far_side (.ref_clk(ref_clk), .rst(rst),
    .matchPulse(matchPulse), .shiftClk(shiftClk), .pulses(pulses),
    .edges(edges));

  // one single transfer; address held until ready, data until ready
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdChk(input string nm, input logic [15:0] a,
                       input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // cycles up to the next match pulse, bounded against a dead timer
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (matchPulse !== 1'h1 && k < 2000);
  endtask

  task automatic t_reset;
    rdChk("control", CTL, 32'h0);
    rdChk("limit", LIM, 32'hFF);
    rdChk("counter", CNT, 32'h0);
    rdChk("flags", FLG, 32'h0);
    rdChk("unmapped", 16'h0100, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_regs;
    bus(1'h1, LIM, 32'h5A);
    rdChk("limit rw", LIM, 32'h5A);
    bus(1'h1, CNT, 32'h33);
    bus(1'h1, CTL, 32'hF8);
    rdChk("control rw", CTL, 32'h78);
    rdChk("counter kept", CNT, 32'h33);
    $display("register test done");
  endtask
  task automatic t_count;
    bus(1'h1, LIM, 32'h3);
    bus(1'h1, CNT, 32'h0);
    for (i = 0; i < 4; i++) begin
      bus(1'h1, CTL, 32'h4 | i);
      gap(n);
      gap(n);
      chk("period", n, 16 * (i == 0 ? 1 : i == 1 ? 4 : 16));
    end
    bus(1'h1, CTL, 32'h0);
    bus(1'h0, CNT, 32'h0);
    held = rd;
    n = pulses;
    repeat (80) @(posedge ref_clk);
    rdChk("held count", CNT, held);
    chk("no pulse", pulses, n);
    chk("shift edges", edges, pulses);
    $display("count test done");
  endtask
  task automatic t_post;
    bus(1'h1, LIM, 32'h1);
    bus(1'h1, ENA, 32'h2);
    foreach (codes[j]) begin
      bus(1'h1, CTL, 32'h0);
      bus(1'h1, FLG, 32'h2);
      bus(1'h1, CNT, 32'h0);
      bus(1'h1, CTL, (codes[j] << 3) | 32'h4);
      n = 0;
      c = 0;
      do begin
        @(posedge ref_clk);
        c++;
        if (matchPulse === 1'h1) n++;
      end while (irq !== 1'h1 && c < 600);
      @(posedge ref_clk);
      if (matchPulse === 1'h1) n++;
      chk("post ratio", n, codes[j] + 1);
    end
    bus(1'h1, CTL, 32'h0);
    bus(1'h1, ENA, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("masked irq", irq, 1'h0);
    rdChk("flag latched", FLG, 32'h2);
    bus(1'h1, ENA, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("unmasked irq", irq, 1'h1);
    bus(1'h1, FLG, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("cleared irq", irq, 1'h0);
    $display("postscale test done");
  endtask

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  // whole run needs well under 20000 cycles
  initial begin
    #2000000;
    fails++;
    complete_run;
  end
  initial begin
    rst = 1'h1;
    hsel = 1'h0;
    hwrite = 1'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 16'h0000;
    hwdata = 32'h0;
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    t_reset;
    t_regs;
    t_count;
    t_post;
    complete_run;
  end
endmodule

// ### hdl/pmt8_pkg.sv
// types shared by the 8-bit period match timer
package pmt8_pkg;

  // ahb-lite slave side request, as sampled in an address phase
  typedef struct packed {
    logic        sel;
    logic [15:0] addr;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
    logic        ready;
  } pmt8_ahb_req_t;

  // answer driven back to the master
  typedef struct packed {
    logic        readyOut;
    logic        resp;
    logic [31:0] rdata;
  } pmt8_ahb_rsp_t;

  // bus data phase sequencing
  typedef enum logic [1:0] {
    PMT8_BUS_IDLE  = 2'b00,
    PMT8_BUS_WRITE = 2'b01,
    PMT8_BUS_READ  = 2'b10
  } pmt8_bus_t;

  // every flip-flop of the timer
  typedef struct packed {
    logic [1:0]  instDiv;
    logic [3:0]  preCnt;
    logic [3:0]  postCnt;
    logic [7:0]  counter;
    logic [7:0]  limit;
    logic [6:0]  control;
    logic        flag;
    logic        enable;
    logic        irq;
    logic        matchPulse;
    logic        shiftClk;
    pmt8_bus_t   bus;
    logic [13:0] dpIdx;
    pmt8_ahb_rsp_t rsp;
  } pmt8_state_t;

endpackage

// ### hdl/pmt8_regs.svh
// register map, field positions, reset values and rates of the 8-bit timer
//
// Summary of operation
// - While running, the counter counts up by one from zero on each prescaled instruction-clock tick.
// - Divider select 00 gives divide by 1, 01 divide by 4 and 10 divide by 16.
// - Every counter tick compares counter with period limit and flags a match when equal.
// - A match returns the counter to zero and also clocks the postscaler.
// - Reset clears the counter and sets the period limit to all ones.
// - Writes to counter or control, and any reset, clear prescaler and postscaler.
// - A control write leaves the counter value untouched.
// - Counter and period limit are readable and writable at any time.
// - Control bit 2 runs the timer when one and stops it when zero.
// - Control bits 6 to 3 set 1 to 16 matches per flag event, one step per code.
// - Completion of the postscaler count latches the match event flag, flag register bit 1.
// - The interrupt is raised only while enable register bit 1 is set.
// - The unscaled match pulse goes to the capture/compare/PWM units.
// - The timer output is offered as shift clock to the serial port.
`ifndef PMT8_REGS_SVH
`define PMT8_REGS_SVH

// word indices; byte address is four times the index
`define PMT8_IDX_CONTROL   14'h0FCA
`define PMT8_IDX_LIMIT     14'h0FCB
`define PMT8_IDX_COUNTER   14'h0FCC
`define PMT8_IDX_FLAGS     14'h0FC0
`define PMT8_IDX_ENABLES   14'h0FC1

// control fields
`define PMT8_CTL_DIV_LSB   0
`define PMT8_CTL_RUN_BIT   2
`define PMT8_CTL_POST_LSB  3
`define PMT8_CTL_WIDTH     7

// interrupt bit position in flag and enable registers
`define PMT8_EVT_BIT       1

// reset values
`define PMT8_RST_CONTROL   7'h00
`define PMT8_RST_COUNTER   8'h00
`define PMT8_RST_LIMIT     8'hFF

// instruction clock is the system clock divided by four
`define PMT8_INST_DIV      2'h3
`define PMT8_PRE_DIV4      4'h3
`define PMT8_PRE_DIV16     4'hF

`endif

// ### hdl/pmt8_timer.sv
// 8-bit period match timer with ahb-lite register access
`include "pmt8_regs.svh"

module pmt8_timer
  import pmt8_pkg::*;
(
  input  wire logic        ref_clk,     // system clock, 10 MHz
  input  wire logic        rst,         // async reset, active high
  input  wire logic        hsel,        // slave select
  input  wire logic [15:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write when high
  input  wire logic [2:0]  hsize,       // transfer size
  input  wire logic [31:0] hwdata,      // write data
  input  wire logic        hready,      // bus ready
  output logic             hreadyout,   // slave ready
  output logic             hresp,       // always okay
  output logic [31:0]      hrdata,      // read data
  output logic             irq,         // level interrupt
  output logic             matchPulse,  // unscaled match, pwm time base
  output logic             shiftClk     // serial port shift clock source
);

  pmt8_state_t   cur;
  pmt8_state_t   next_cur;
  pmt8_ahb_req_t req;

  // gather bus inputs
  assign req = '{sel: hsel, addr: haddr, trans: htrans, write: hwrite,
                 size: hsize, ready: hready};

  // prescale terminal count for a divider code
  function automatic logic [3:0] preLimit(input logic [1:0] code);
    case (code)
      2'b00:   preLimit = 4'h0;
      2'b01:   preLimit = `PMT8_PRE_DIV4;
      default: preLimit = `PMT8_PRE_DIV16;
    endcase
  endfunction

  // register read mux, shared by the read data phase
  function automatic logic [31:0] readMux(input pmt8_state_t s,
                                          input logic [13:0] idx);
    readMux = 32'h0000_0000;
    case (idx)
      `PMT8_IDX_CONTROL: readMux = {25'h0, s.control};
      `PMT8_IDX_COUNTER: readMux = {24'h0, s.counter};
      `PMT8_IDX_LIMIT:   readMux = {24'h0, s.limit};
      `PMT8_IDX_FLAGS:
        readMux[`PMT8_EVT_BIT] = s.flag;
      `PMT8_IDX_ENABLES:
        readMux[`PMT8_EVT_BIT] = s.enable;
      default:           readMux = 32'h0000_0000;
    endcase
  endfunction

  logic        accept;
  logic        wrCtl;
  logic        wrCnt;
  logic        wrLim;
  logic        wrFlg;
  logic        wrEna;
  logic        instTick;
  logic        cntTick;
  logic        match;
  logic        postDone;
  logic        running;
  logic [3:0]  postSel;

  // next-state logic
  always_comb begin
    next_cur = cur;
    accept   = req.sel && req.trans[1] && req.ready;
    wrCtl    = (cur.bus == PMT8_BUS_WRITE) &&
               (cur.dpIdx == `PMT8_IDX_CONTROL);
    wrCnt    = (cur.bus == PMT8_BUS_WRITE) &&
               (cur.dpIdx == `PMT8_IDX_COUNTER);
    wrLim    = (cur.bus == PMT8_BUS_WRITE) &&
               (cur.dpIdx == `PMT8_IDX_LIMIT);
    wrFlg    = (cur.bus == PMT8_BUS_WRITE) &&
               (cur.dpIdx == `PMT8_IDX_FLAGS);
    wrEna    = (cur.bus == PMT8_BUS_WRITE) &&
               (cur.dpIdx == `PMT8_IDX_ENABLES);
    running  = cur.control[`PMT8_CTL_RUN_BIT];
    postSel  = cur.control[`PMT8_CTL_POST_LSB +: 4];

    // free-running quarter-rate tick, the instruction clock
    next_cur.instDiv = cur.instDiv + 2'h1;
    instTick = (cur.instDiv == `PMT8_INST_DIV);

    // prescaler; stopped timer does not advance it
    cntTick = 1'b0;
    if (running && instTick) begin
      if (cur.preCnt >= preLimit(cur.control[1:0])) begin
        next_cur.preCnt = 4'h0;
        cntTick = 1'b1;
      end else begin
        next_cur.preCnt = cur.preCnt + 4'h1;
      end
    end

    // compare on every counter tick; match rolls the count to zero
    match = cntTick && (cur.counter == cur.limit);
    if (cntTick) begin
      if (match) begin
        next_cur.counter = 8'h00;
      end else begin
        next_cur.counter = cur.counter + 8'h01;
      end
    end

    // postscaler clocked by the unscaled match
    postDone = 1'b0;
    if (match) begin
      if (cur.postCnt >= postSel) begin
        next_cur.postCnt = 4'h0;
        postDone = 1'b1;
      end else begin
        next_cur.postCnt = cur.postCnt + 4'h1;
      end
    end

    // outputs toward pwm units and serial port
    next_cur.matchPulse = match;
    if (match) begin
      next_cur.shiftClk = ~cur.shiftClk;
    end

    // register writes in the data phase; software wins over counting
    if (wrCtl) begin
      next_cur.control = hwdata[`PMT8_CTL_WIDTH-1:0];
      next_cur.preCnt  = 4'h0;
      next_cur.postCnt = 4'h0;
    end
    if (wrCnt) begin
      next_cur.counter = hwdata[7:0];
      next_cur.preCnt  = 4'h0;
      next_cur.postCnt = 4'h0;
    end
    if (wrLim) begin
      next_cur.limit = hwdata[7:0];
    end
    if (wrEna) begin
      next_cur.enable = hwdata[`PMT8_EVT_BIT];
    end

    // sticky flag: write one clears, a new event wins over the clear
    if (wrFlg && hwdata[`PMT8_EVT_BIT]) begin
      next_cur.flag = 1'b0;
    end
    if (postDone) begin
      next_cur.flag = 1'b1;
    end

    // irq follows the registered flag and enable of the next cycle
    next_cur.irq = next_cur.flag && next_cur.enable;

    // bus sequencing; reads take one wait state so a write just
    // before them has landed before the value is sampled
    next_cur.rsp.resp = 1'b0;
    case (cur.bus)
      PMT8_BUS_READ: begin
        next_cur.rsp.rdata    = readMux(cur, cur.dpIdx);
        next_cur.rsp.readyOut = 1'b1;
        next_cur.bus          = PMT8_BUS_IDLE;
      end
      PMT8_BUS_IDLE, PMT8_BUS_WRITE: begin
        next_cur.bus = PMT8_BUS_IDLE;
        if (accept) begin
          next_cur.dpIdx = req.addr[15:2];
          if (req.write) begin
            next_cur.bus = PMT8_BUS_WRITE;
          end else begin
            next_cur.bus          = PMT8_BUS_READ;
            next_cur.rsp.readyOut = 1'b0;
          end
        end
      end
      default: begin
        next_cur.bus          = PMT8_BUS_IDLE;
        next_cur.rsp.readyOut = 1'b1;
      end
    endcase
  end

  // state register; reset values hold the timer stopped and idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur.instDiv    <= 2'h0;
      cur.preCnt     <= 4'h0;
      cur.postCnt    <= 4'h0;
      cur.counter    <= `PMT8_RST_COUNTER;
      cur.limit      <= `PMT8_RST_LIMIT;
      cur.control    <= `PMT8_RST_CONTROL;
      cur.flag       <= 1'b0;
      cur.enable     <= 1'b0;
      cur.irq        <= 1'b0;
      cur.matchPulse <= 1'b0;
      cur.shiftClk   <= 1'b0;
      cur.bus        <= PMT8_BUS_IDLE;
      cur.dpIdx      <= 14'h0000;
      cur.rsp        <= '{readyOut: 1'b1, resp: 1'b0,
                          rdata: 32'h0000_0000};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign hreadyout  = cur.rsp.readyOut;
  assign hresp      = cur.rsp.resp;
  assign hrdata     = cur.rsp.rdata;
  assign irq        = cur.irq;
  assign matchPulse = cur.matchPulse;
  assign shiftClk   = cur.shiftClk;

endmodule
